// >>> rtl/udb_uart.v
// Serial port with driver enable, interrupts, overrun handling and timer.
// Assumes a register port with one-cycle strobes and read data one cycle
// later; serial input is already synchronous to core_clk.
`timescale 1ns/1ps
`include "udb_map.vh"
module udb_uart #(
    parameter DIV_W = 16
) (
    input  wire                   core_clk,
    input  wire                   resetn,
    input  wire [`UDB_ADDR_W-1:0] reg_addr,
    input  wire [7:0]             reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output reg  [7:0]             reg_rdata,
    input  wire                   serial_in_pin,
    output reg                    serial_out_pin,
    output wire                   line_driver_on,
    output wire                   tx_irq,
    output wire                   rx_irq
);
    localparam ST_IDLE  = 5'b00001;
    localparam ST_SETUP = 5'b00010;
    localparam ST_SHIFT = 5'b00100;
    localparam ST_TAIL  = 5'b01000;
    localparam ST_SPARE = 5'b10000;

    reg  [7:0]       ctl0_q, ctl1_q, addr_match_q;
    reg  [DIV_W-1:0] div_q;
    wire             wr_data = reg_wr && reg_addr == `UDB_OFF_DATA;
    wire             rd_data = reg_rd && reg_addr == `UDB_OFF_DATA;
    wire             tx_on   = ctl0_q[`UDB_CTL0_TX_ON];
    wire             rx_on   = ctl0_q[`UDB_CTL0_RX_ON];
    wire             nine    = ctl1_q[`UDB_CTL1_NINE_BIT];
    wire             div_reload;
    wire             div_wr  = reg_wr && (reg_addr == `UDB_OFF_DIV_HI ||
                                          reg_addr == `UDB_OFF_DIV_LO);

    // Bit rate is system clock / (16 * divisor).
    udb_baud_divider #(.WIDTH(DIV_W)) u_div (
        .core_clk (core_clk),
        .resetn   (resetn),
        .divisor  (div_q),
        .restart  (div_wr),
        .reload   (div_reload)
    );

    // Transmit side: sixteen reloads make one bit period.
    reg  [4:0] tx_st_q;
    reg  [3:0] tx_ovs_q;
    reg  [3:0] tx_bit_q;
    reg  [10:0] tx_sh_q;
    reg  [7:0] tx_hold_q;
    reg        tx_full_q, tx_empty_flag_q, drv_q;
    wire       tx_tick  = div_reload && tx_ovs_q == 4'hF;
    wire       par_bit  = ^tx_hold_q ^ ctl0_q[`UDB_CTL0_PAR_ODD];
    wire       ninth_on = nine || ctl0_q[`UDB_CTL0_PAR_ON];
    wire       ninth    = nine ? ctl1_q[`UDB_CTL1_NINTH_TX] : par_bit;
    wire [3:0] frame_n  = 4'h9 + {3'h0, ninth_on}
                        + {3'h0, ctl0_q[`UDB_CTL0_TWO_STOP]};

    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_st_q         <= ST_IDLE;
            tx_ovs_q        <= 4'h0;
            tx_bit_q        <= 4'h0;
            tx_sh_q         <= 11'h7FF;
            tx_hold_q       <= 8'h00;
            tx_full_q       <= 1'b0;
            tx_empty_flag_q <= 1'b1;
            drv_q           <= 1'b0;
            serial_out_pin  <= 1'b1;
        end
        else
        begin
            if (div_reload)
                tx_ovs_q <= tx_ovs_q + 4'h1;
            if (wr_data)
            begin
                tx_hold_q       <= reg_wdata;
                tx_full_q       <= 1'b1;
                tx_empty_flag_q <= 1'b0;
            end
            case (tx_st_q)
                ST_IDLE:
                begin
                    serial_out_pin <= 1'b1;
                    drv_q          <= 1'b0;
                    if (wr_data && tx_on)
                    begin
                        drv_q    <= 1'b1;
                        tx_ovs_q <= 4'hF;
                        tx_bit_q <= 4'hF;
                        tx_st_q  <= ST_SETUP;
                    end
                end
                ST_SETUP:
                    // The first reload may come at once; one extra keeps
                    // the setup at least a whole bit period long.
                    if (tx_tick && tx_bit_q == 4'hF)
                        tx_bit_q <= 4'h0;
                    else if (tx_tick)
                    begin
                        tx_sh_q   <= {2'b11, ninth_on ? ninth : 1'b1,
                                      tx_hold_q};
                        tx_full_q <= wr_data;
                        serial_out_pin <= 1'b0;
                        tx_bit_q  <= 4'h0;
                        tx_st_q   <= ST_SHIFT;
                    end
                ST_SHIFT:
                    if (tx_tick)
                    begin
                        if (tx_bit_q == 4'h0 && !tx_full_q && !wr_data)
                            tx_empty_flag_q <= 1'b1;
                        if (tx_bit_q == frame_n)
                            tx_st_q <= ST_TAIL;
                        else
                        begin
                            serial_out_pin <= tx_sh_q[0];
                            tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
                            tx_bit_q <= tx_bit_q + 4'h1;
                        end
                    end
                ST_TAIL:
                begin
                    // Stop bit ended last cycle; the driver stays on for
                    // this one clock while a queued byte is looked for.
                    if (tx_full_q || wr_data)
                    begin
                        tx_sh_q   <= {2'b11, ninth_on ? ninth : 1'b1,
                                      wr_data ? reg_wdata : tx_hold_q};
                        tx_full_q <= 1'b0;
                        serial_out_pin <= 1'b0;
                        tx_bit_q  <= 4'h0;
                        tx_ovs_q  <= 4'h0;
                        tx_st_q   <= ST_SHIFT;
                    end
                    else
                    begin
                        drv_q   <= 1'b0;
                        tx_st_q <= ST_IDLE;
                    end
                end
                default:
                    tx_st_q <= ST_IDLE;
            endcase
        end
    end

    // Driver is held on from load through the last stop bit.
    assign line_driver_on = drv_q ^ ctl1_q[`UDB_CTL1_DRV_POL];
    assign tx_irq = tx_empty_flag_q && tx_on;

    // Receive side: sample at mid-bit using the 16x tick.
    reg  [2:0] rx_st_q;
    reg  [3:0] rx_ovs_q, rx_bit_q;
    reg  [8:0] rx_sh_q;
    reg  [7:0] rx_data_q;
    reg        avail_q, par_err_q, frm_err_q, brk_q, ovr_q;
    reg        pend_ovr_q, pend_brk_q, mp_match_q, data_irq_q, ninth_rx_q;
    wire [3:0] rx_n     = 4'h8 + {3'h0, ninth_on};
    wire       mid      = div_reload && rx_ovs_q == 4'h7;
    wire       is_addr  = nine && rx_sh_q[8];
    wire       frame_ok = serial_in_pin;
    wire       is_brk   = ~|rx_sh_q && !serial_in_pin;
    wire [1:0] mp_mode  = {ctl1_q[`UDB_CTL1_MODE_HI],
                           ctl1_q[`UDB_CTL1_MODE_LO]};
    wire       addr_eq  = rx_sh_q[7:0] == addr_match_q;
    reg        want_irq;

    // In nine-bit mode data interrupts follow the address-match mode.
    always @*
    begin
        want_irq = 1'b1;
        if (nine)
        begin
            case (mp_mode)
                2'b00:   want_irq = 1'b1;
                2'b01:   want_irq = is_addr;
                2'b10:   want_irq = is_addr ? addr_eq : mp_match_q;
                default: want_irq = !is_addr && mp_match_q;
            endcase
        end
    end

    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_st_q    <= 3'b001;
            rx_ovs_q   <= 4'h0;
            rx_bit_q   <= 4'h0;
            rx_sh_q    <= 9'h000;
            rx_data_q  <= 8'h00;
            avail_q    <= 1'b0;
            par_err_q  <= 1'b0;
            frm_err_q  <= 1'b0;
            brk_q      <= 1'b0;
            ovr_q      <= 1'b0;
            pend_ovr_q <= 1'b0;
            pend_brk_q <= 1'b0;
            mp_match_q <= 1'b0;
            data_irq_q <= 1'b0;
            ninth_rx_q <= 1'b0;
        end
        else
        begin
            // A read clears the flags or loads a pending overrun; an arriving event below wins.
            if (rd_data)
            begin
                avail_q    <= 1'b0;
                par_err_q  <= 1'b0;
                frm_err_q  <= 1'b0;
                brk_q      <= 1'b0;
                data_irq_q <= 1'b0;
                ovr_q      <= 1'b0;
                if (pend_ovr_q)
                begin
                    avail_q    <= 1'b1;
                    ovr_q      <= 1'b1;
                    brk_q      <= pend_brk_q;
                    pend_ovr_q <= 1'b0;
                    pend_brk_q <= 1'b0;
                end
            end
            if (div_reload)
                rx_ovs_q <= rx_ovs_q + 4'h1;
            case (rx_st_q)
                3'b001:
                    if (!serial_in_pin && rx_on)
                    begin
                        rx_ovs_q <= 4'h0;
                        rx_bit_q <= 4'h0;
                        rx_st_q  <= 3'b010;
                    end
                3'b010:
                    if (mid)
                    begin
                        if (rx_bit_q == 4'h0 && serial_in_pin)
                            rx_st_q <= 3'b001;
                        else if (rx_bit_q == rx_n + 4'h1)
                        begin
                            rx_st_q <= 3'b100;
                        end
                        else
                        begin
                            if (rx_bit_q != 4'h0)
                                rx_sh_q <= ninth_on ?
                                    {serial_in_pin, rx_sh_q[8:1]} :
                                    {1'b0, serial_in_pin, rx_sh_q[7:1]};
                        end
                        rx_bit_q <= rx_bit_q + 4'h1;
                    end
                3'b100:
                begin
                    rx_st_q <= 3'b001;
                    if (is_addr)
                        mp_match_q <= addr_eq;
                    if (avail_q && !rd_data || pend_ovr_q)
                    begin
                        // Keep the unread byte; report later.
                        pend_ovr_q <= 1'b1;
                        pend_brk_q <= is_brk;
                    end
                    else
                    begin
                        rx_data_q  <= rx_sh_q[7:0];
                        ninth_rx_q <= rx_sh_q[8];
                        avail_q    <= 1'b1;
                        frm_err_q  <= !frame_ok;
                        brk_q      <= is_brk;
                        par_err_q  <= ctl0_q[`UDB_CTL0_PAR_ON] && !nine &&
                            (^rx_sh_q ^ ctl0_q[`UDB_CTL0_PAR_ODD]);
                        data_irq_q <= want_irq;
                    end
                end
                default:
                    rx_st_q <= 3'b001;
            endcase
        end
    end

    // Divider interrupt: receiver off uses the divider control bit.
    wire div_irq_en = rx_on ? 1'b0 : ctl1_q[`UDB_CTL1_DIV_CTL];
    reg  div_irq_q;
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            div_irq_q <= 1'b0;
        else if (div_reload && div_irq_en)
            div_irq_q <= 1'b1;
        else if (reg_rd && reg_addr == `UDB_OFF_STAT0)
            div_irq_q <= 1'b0;
    end

    assign rx_irq = (data_irq_q && ctl1_q[`UDB_CTL1_DATA_IRQ])
                  || ovr_q || frm_err_q || brk_q || div_irq_q;

    // Register port.
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctl0_q       <= `UDB_CTL0_RESET;
            ctl1_q       <= `UDB_CTL1_RESET;
            div_q        <= `UDB_DIV_RESET;
            addr_match_q <= `UDB_ADDR_MATCH_RESET;
            reg_rdata    <= 8'h00;
        end
        else
        begin
            if (reg_wr)
            begin
                case (reg_addr)
                    `UDB_OFF_CTL0:   ctl0_q <= reg_wdata;
                    `UDB_OFF_CTL1:   ctl1_q <= reg_wdata;
                    `UDB_OFF_STAT1:  addr_match_q <= reg_wdata;
                    `UDB_OFF_DIV_HI: div_q[15:8] <= reg_wdata;
                    `UDB_OFF_DIV_LO: div_q[7:0] <= reg_wdata;
                    default:         ;
                endcase
            end
            reg_rdata <= 8'h00;
            if (reg_rd)
            begin
                case (reg_addr)
                    `UDB_OFF_DATA:   reg_rdata <= rx_data_q;
                    `UDB_OFF_STAT0:  reg_rdata <= {avail_q, par_err_q,
                        ovr_q, frm_err_q, brk_q, tx_empty_flag_q,
                        tx_st_q == ST_IDLE, div_irq_q};
                    `UDB_OFF_CTL0:   reg_rdata <= ctl0_q;
                    `UDB_OFF_CTL1:   reg_rdata <= ctl1_q;
                    `UDB_OFF_STAT1:  reg_rdata <= {7'h00, ninth_rx_q};
                    `UDB_OFF_DIV_HI: reg_rdata <= div_q[15:8];
                    `UDB_OFF_DIV_LO: reg_rdata <= div_q[7:0];
                    default:         reg_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule // udb_uart

// >>> rtl/udb_map.vh
// Register map, field positions, reset values and timing counts for the
// serial port with line driver enable.
// Assumes inclusion by bare name from the design files.
`ifndef UDB_MAP_VH
`define UDB_MAP_VH

`define UDB_ADDR_W          12
`define UDB_OFF_DATA        12'hF40
`define UDB_OFF_STAT0       12'hF41
`define UDB_OFF_CTL0        12'hF42
`define UDB_OFF_CTL1        12'hF43
`define UDB_OFF_STAT1       12'hF44
`define UDB_OFF_DIV_HI      12'hF46
`define UDB_OFF_DIV_LO      12'hF47

`define UDB_CTL0_TX_ON      7
`define UDB_CTL0_RX_ON      6
`define UDB_CTL0_PAR_ON     4
`define UDB_CTL0_PAR_ODD    3
`define UDB_CTL0_TWO_STOP   1

`define UDB_CTL1_MODE_HI    7
`define UDB_CTL1_NINE_BIT   6
`define UDB_CTL1_MODE_LO    5
`define UDB_CTL1_NINTH_TX   4
`define UDB_CTL1_DRV_POL    3
`define UDB_CTL1_DIV_CTL    2
`define UDB_CTL1_DATA_IRQ   1

`define UDB_CTL0_RESET      8'h00
`define UDB_CTL1_RESET      8'h00
`define UDB_DIV_RESET       16'h0000
`define UDB_ADDR_MATCH_RESET 8'h00

`define UDB_OVERSAMPLE      16
`define UDB_OVS_W           4

`endif

// >>> rtl/udb_baud_divider.v
// Baud divider: counts system clocks down from the 16-bit divisor and pulses
// on each reload. Assumes one clock, asynchronous active-low reset.
`timescale 1ns/1ps
module udb_baud_divider #(
    parameter WIDTH = 16
) (
    input  wire             core_clk,
    input  wire             resetn,
    input  wire [WIDTH-1:0] divisor,
    input  wire             restart,
    output reg              reload
);
    reg [WIDTH-1:0] count_q;

    // A divisor of zero is treated as one so the divider never stalls.
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count_q <= {WIDTH{1'b0}};
            reload  <= 1'b0;
        end
        else if (restart)
        begin
            count_q <= divisor;
            reload  <= 1'b0;
        end
        else if (count_q <= {{(WIDTH-1){1'b0}}, 1'b1})
        begin
            count_q <= divisor;
            reload  <= 1'b1;
        end
        else
        begin
            count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
            reload  <= 1'b0;
        end
    end
endmodule // udb_baud_divider

// >>> tb/udb_uart_sva.sv
// Checker for the serial port: line driver envelope, holding-empty flag,
// read port and divider interrupt. Sees only the top-level ports.
`timescale 1ns/1ps
`include "udb_map.vh"
module udb_uart_sva (
    input wire                   core_clk,
    input wire                   resetn,
    input wire [`UDB_ADDR_W-1:0] reg_addr,
    input wire [7:0]             reg_wdata,
    input wire                   reg_wr,
    input wire                   reg_rd,
    input wire [7:0]             reg_rdata,
    input wire                   serial_in_pin,
    input wire                   serial_out_pin,
    input wire                   line_driver_on,
    input wire                   tx_irq,
    input wire                   rx_irq
);
    // The timer bound only suits divisors up to this value.
    localparam int DLIM = 1000;
    reg        pol_q;
    reg        txon_q;
    reg        rxon_q;
    reg        divc_q;
    reg        first_q;
    reg [15:0] div_q;
    reg [31:0] act_cnt_q;
    wire       act = line_driver_on ^ pol_q;
    wire       wr_data = reg_wr && reg_addr == `UDB_OFF_DATA;
    wire [31:0] bit_len = (div_q == 16'h0000) ? 32'h10
                                              : {12'h000, div_q, 4'h0};

    always @(posedge core_clk or negedge resetn)
        if (!resetn)
        begin
            pol_q     <= 1'h0;
            txon_q    <= 1'h0;
            rxon_q    <= 1'h0;
            divc_q    <= 1'h0;
            first_q   <= 1'h1;
            div_q     <= `UDB_DIV_RESET;
            act_cnt_q <= 32'h0;
        end
        else
        begin
            if (reg_wr && reg_addr == `UDB_OFF_CTL1)
            begin
                pol_q  <= reg_wdata[`UDB_CTL1_DRV_POL];
                divc_q <= reg_wdata[`UDB_CTL1_DIV_CTL];
            end
            if (reg_wr && reg_addr == `UDB_OFF_CTL0)
                {txon_q, rxon_q} <= reg_wdata[7:6];
            if (reg_wr && reg_addr == `UDB_OFF_DIV_HI)
                div_q[15:8] <= reg_wdata;
            if (reg_wr && reg_addr == `UDB_OFF_DIV_LO)
                div_q[7:0] <= reg_wdata;
            act_cnt_q <= act ? act_cnt_q + 32'h1 : 32'h0;
            first_q   <= !act ? 1'h1 : (!serial_out_pin ? 1'h0 : first_q);
        end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    property p_drv_on;
        wr_data && txon_q |=> act;
    endproperty
    a_drv_on: assert property (p_drv_on)
        else $error("driver not on after write");
    property p_drv_setup;
        first_q && act && !serial_out_pin |->
            act_cnt_q >= bit_len && act_cnt_q <= 2 * bit_len;
    endproperty
    a_drv_setup: assert property (p_drv_setup)
        else $error("driver setup out of range");
    property p_drv_env;
        !act |-> serial_out_pin;
    endproperty
    a_drv_env: assert property (p_drv_env)
        else $error("line low without driver");
    property p_drv_idle;
        !txon_q |-> !act;
    endproperty
    a_drv_idle: assert property (p_drv_idle)
        else $error("driver level wrong when idle");
    property p_tx_irq_off;
        !txon_q |-> !tx_irq;
    endproperty
    a_tx_irq_off: assert property (p_tx_irq_off)
        else $error("tx irq with tx off");
    property p_txe_clr;
        wr_data |=> !tx_irq;
    endproperty
    a_txe_clr: assert property (p_txe_clr)
        else $error("tx irq not cleared");
    property p_div_irq;
        !rxon_q && divc_q && $fell(rx_irq) |-> ##[1:DLIM] rx_irq;
    endproperty
    a_div_irq: assert property (p_div_irq)
        else $error("timer irq missing");
    property p_rd_zero;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_zero: assert property (p_rd_zero)
        else $error("read data outside slot");

    c_back_to_back: cover property (wr_data && act);
    c_pol_low: cover property (pol_q && act);
    c_timer: cover property ($rose(rx_irq) && divc_q && !rxon_q);
endmodule // udb_uart_sva

bind udb_uart udb_uart_sva u_sva (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .line_driver_on(line_driver_on),
    .tx_irq(tx_irq), .rx_irq(rx_irq)
);

// >>> tb/udb_line_xcvr.sv
// Line transceiver on a shared bus with a remote sender.
// Assumes drv_en is already the active-high enable of the transceiver.
`timescale 1ns/1ps
module udb_line_xcvr (
    input  wire core_clk,
    input  wire txd,
    input  wire drv_en,
    output wire bus_level
);
    logic remote_en = 1'h0;
    logic remote_bit = 1'h1;
    // Fail-safe bias pulls the undriven bus high, which reads as idle.
    assign bus_level = drv_en ? txd : (remote_en ? remote_bit : 1'h1);

    task automatic send(input [7:0] b, input int bitc, input logic stop_ok);
        int i;
        for (i = 0; i < 10; i++)
        begin
            @(posedge core_clk);
            remote_en  <= 1'h1;
            remote_bit <= (i == 0) ? 1'h0 : ((i == 9) ? stop_ok : b[i - 1]);
            repeat (bitc - 1) @(posedge core_clk);
        end
        @(posedge core_clk);
        remote_en  <= 1'h0;
        remote_bit <= 1'h1;
    endtask
endmodule // udb_line_xcvr

// >>> tb/udb_uart_tb_top.sv
// Self-checking bench for the serial port through its register port.
// Divisor 1 keeps a bit at 16 clocks; the timer uses divisor 4.
`timescale 1ns/1ps
`include "udb_map.vh"
module udb_uart_tb_top;
    localparam int BIT = 16;
    localparam int LIMIT = 20000;
    logic        core_clk = 1'h0;
    logic        resetn = 1'h0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'h0;
    logic        reg_rd = 1'h0;
    logic        pol = 1'h0;
    logic        watch = 1'h0;
    wire  [7:0]  reg_rdata;
    wire         serial_in_pin;
    wire         serial_out_pin;
    wire         line_driver_on;
    wire         tx_irq;
    wire         rx_irq;
    wire         act = line_driver_on ^ pol;
    int          cyc = 0;
    int          drops = 0;
    int          failures = 0;
    int          cmp_count = 0;

    always #5 core_clk = ~core_clk;

    udb_uart #(.DIV_W(16)) dut (
        .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin), .line_driver_on(line_driver_on),
        .tx_irq(tx_irq), .rx_irq(rx_irq)
    );
    udb_line_xcvr xcvr (
        .core_clk(core_clk), .txd(serial_out_pin), .drv_en(act),
        .bus_level(serial_in_pin)
    );

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            failures++;
            print_verdict();
        end
    end
    always @(negedge core_clk)
        if (watch && !act)
            drops++;

    task automatic chk(input string nm, input [31:0] exp, input [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input [11:0] a, input [7:0] d);
        @(posedge core_clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'h1};
        @(posedge core_clk);
        reg_wr <= 1'h0;
        @(negedge core_clk);
    endtask
    task automatic rd(input [11:0] a, output [7:0] d);
        @(posedge core_clk);
        {reg_addr, reg_rd} <= {a, 1'h1};
        @(posedge core_clk);
        reg_rd <= 1'h0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    // Samples one outgoing character at bit centres, LSB first.
    task automatic get_byte(output [7:0] b, output int ts, output [1:0] ti);
        int n;
        int i;
        for (n = 0; serial_out_pin !== 1'h0 && n < 400; n++)
            @(negedge core_clk);
        ts = cyc;
        repeat (BIT / 2) @(negedge core_clk);
        chk("start bit", 0, serial_out_pin);
        ti[0] = tx_irq;
        for (i = 0; i < 8; i++)
        begin
            repeat (BIT) @(negedge core_clk);
            b[i] = serial_out_pin;
            ti[1] = (i == 0) ? tx_irq : ti[1];
        end
        repeat (BIT) @(negedge core_clk);
        chk("stop bit", 1, serial_out_pin);
    endtask

    task automatic t_reset_idle();
        logic [7:0] d;
        chk("idle driver", 0, line_driver_on);
        chk("idle line", 1, serial_out_pin);
        chk("idle irqs", 0, {tx_irq, rx_irq});
        rd(`UDB_OFF_CTL0, d);
        chk("ctl0 reset", `UDB_CTL0_RESET, d);
        rd(12'hF45, d);
        chk("unmapped read", 8'h00, d);
        $display("test reset_idle done");
    endtask
    task automatic t_tx(input logic p);
        logic [7:0] b;
        logic [1:0] ti;
        int ts;
        int n;
        pol = p;
        wr(`UDB_OFF_DIV_HI, 8'h00);
        wr(`UDB_OFF_DIV_LO, 8'h01);
        wr(`UDB_OFF_CTL1, {4'h0, p, 3'h0});
        chk("driver level", 0, act);
        wr(`UDB_OFF_CTL0, 8'h80);
        wr(`UDB_OFF_DATA, 8'hA5);
        chk("driver on", 1, act);
        drops = 0;
        watch = 1'h1;
        get_byte(b, ts, ti);
        chk("first byte", 8'hA5, b);
        chk("empty flag timing", 2'h2, ti);
        wr(`UDB_OFF_DATA, 8'h3C);
        chk("empty flag cleared", 0, tx_irq);
        get_byte(b, ts, ti);
        chk("second byte", 8'h3C, b);
        watch = 1'h0;
        chk("no gap", 0, drops);
        for (n = 0; act !== 1'h0 && n < 100; n++) @(negedge core_clk);
        chk("release time", ts + 10 * BIT + 1, cyc);
        wr(`UDB_OFF_CTL0, 8'h00);
        chk("tx irq off", 0, tx_irq);
        $display("test tx done");
    endtask
    task automatic t_rx_errors();
        logic [7:0] d;
        // Polarity goes back to high so the transceiver lets the remote in.
        pol = 1'h0;
        wr(`UDB_OFF_CTL1, 8'h00);
        wr(`UDB_OFF_CTL0, 8'h40);
        xcvr.send(8'h3C, BIT, 1'h1);
        repeat (12) @(negedge core_clk);
        chk("data irq masked", 0, rx_irq);
        rd(`UDB_OFF_DATA, d);
        chk("rx byte", 8'h3C, d);
        rd(`UDB_OFF_STAT0, d);
        chk("avail cleared", 0, d[7]);
        xcvr.send(8'h5A, BIT, 1'h0);
        repeat (12) @(negedge core_clk);
        chk("framing irq", 1, rx_irq);
        rd(`UDB_OFF_STAT0, d);
        chk("framing flag", 1, d[4]);
        rd(`UDB_OFF_DATA, d);
        rd(`UDB_OFF_STAT0, d);
        chk("flags cleared", 8'h00, d & 8'hD8);
        xcvr.send(8'h00, BIT, 1'h0);
        repeat (12) @(negedge core_clk);
        chk("break irq", 1, rx_irq);
        rd(`UDB_OFF_STAT0, d);
        chk("break flag", 1, d[3]);
        rd(`UDB_OFF_DATA, d);
        rd(`UDB_OFF_STAT0, d);
        chk("break cleared", 8'h00, d & 8'hD8);
        $display("test rx_errors done");
    endtask
    task automatic t_overrun();
        logic [7:0] d;
        wr(`UDB_OFF_CTL1, 8'h02);
        xcvr.send(8'h11, BIT, 1'h1);
        repeat (12) @(negedge core_clk);
        chk("data irq", 1, rx_irq);
        xcvr.send(8'h22, BIT, 1'h1);
        repeat (12) @(negedge core_clk);
        rd(`UDB_OFF_STAT0, d);
        chk("overrun hidden", 8'h80, d & 8'hA0);
        rd(`UDB_OFF_DATA, d);
        chk("held byte", 8'h11, d);
        rd(`UDB_OFF_STAT0, d);
        chk("overrun shown", 8'hA0, d & 8'hA0);
        rd(`UDB_OFF_DATA, d);
        rd(`UDB_OFF_STAT0, d);
        chk("overrun cleared", 8'h00, d & 8'hA0);
        xcvr.send(8'h33, BIT, 1'h1);
        repeat (12) @(negedge core_clk);
        rd(`UDB_OFF_DATA, d);
        chk("next byte", 8'h33, d);
        wr(`UDB_OFF_CTL0, 8'h00);
        $display("test overrun done");
    endtask
    task automatic t_timer();
        logic [7:0] d;
        int n;
        int t0;
        wr(`UDB_OFF_CTL1, 8'h00);
        wr(`UDB_OFF_DIV_LO, 8'h04);
        repeat (20) @(negedge core_clk);
        chk("timer irq off", 0, rx_irq);
        wr(`UDB_OFF_CTL1, 8'h04);
        for (n = 0; rx_irq !== 1'h1 && n < 20; n++) @(negedge core_clk);
        t0 = cyc;
        rd(`UDB_OFF_STAT0, d);
        chk("timer flag", 1, d[0]);
        for (n = 0; rx_irq !== 1'h1 && n < 20; n++) @(negedge core_clk);
        chk("timer interval", t0 + 4, cyc);
        $display("test timer done");
    endtask

    initial
    begin
        repeat (20) @(posedge core_clk);
        resetn <= 1'h1;
        @(negedge core_clk);
        t_reset_idle();
        t_tx(1'h0);
        t_tx(1'h1);
        t_rx_errors();
        t_overrun();
        t_timer();
        print_verdict();
    end
endmodule // udb_uart_tb_top
